// ### hw/fot_pkg.sv
package fot_pkg;

	localparam int NCAP    = 4;
	localparam int NPORT   = 4;
	localparam int NPART   = 2;
	localparam int CNT_W   = 32;
	localparam int SEL_W   = 2;
	localparam int MODE_W  = 4;
	localparam int PNUM_W  = 4;
	localparam int DEV_W   = 5;
	localparam int STATE_W = 2;
	localparam int TICK_W  = 7;

	// watchdog step time and the clock period, both in ns
	localparam int CLK_PERIOD_NS    = 10;
	localparam int WATCHDOG_STEP_NS = 1000;
	localparam int CYCLES_PER_US    = WATCHDOG_STEP_NS / CLK_PERIOD_NS;
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(CYCLES_PER_US - 1);

	// address map: bits 7:6 pick the block, 5:4 the instance, 3:2 the word
	localparam logic [1:0] BLK_CAP  = 2'h0;
	localparam logic [1:0] BLK_PORT = 2'h1;
	localparam logic [1:0] BLK_PART = 2'h2;
	localparam logic [1:0] REG_CTL  = 2'h0;
	localparam logic [1:0] REG_STS  = 2'h1;
	localparam logic [1:0] REG_TMR  = 2'h2;
	localparam logic [1:0] REG_FCTL = 2'h1;
	localparam logic [1:0] REG_PSTS = 2'h2;

	// capability_control_reg fields
	localparam int CTL_SWTRIG_BIT = 0;
	localparam int CTL_SIGEN_BIT  = 1;
	localparam int CTL_SIGPOL_BIT = 2;
	localparam int CTL_TIMEN_BIT  = 3;
	// capability_status_reg field
	localparam int STS_MODE_BIT = 0;
	localparam logic MODE_PRIMARY   = 1'b0;
	localparam logic MODE_SECONDARY = 1'b1;
	localparam logic [CNT_W-1:0] CNT_ONE = 32'h1;

	// port_control_reg / partition_control_reg fields
	localparam int EN_BIT         = 0;
	localparam int SEL_LSB        = 1;
	localparam int PORT_MODE_LSB  = 4;
	localparam int PORT_PART_LSB  = 8;
	localparam int PORT_DEV_LSB   = 16;
	localparam int PART_STATE_LSB = 4;
	// failover settings regs: primary half at 0, secondary half at 16
	localparam int FS_PRI_LSB  = 0;
	localparam int FS_SEC_LSB  = 16;
	localparam int FS_MODE_OFS = 0;
	localparam int FS_PART_OFS = 4;
	localparam int FS_DEV_OFS  = 8;
	// status flags, write one to clear
	localparam int FLAG_PRI_BIT = 0;
	localparam int FLAG_SEC_BIT = 1;

	typedef struct packed {
		logic [NCAP-1:0]                  sig_en;
		logic [NCAP-1:0]                  sig_pol;
		logic [NCAP-1:0]                  tim_en;
		logic [NCAP-1:0]                  mode;
		logic [NCAP-1:0]                  pin_prev;
		logic                             armed;
		logic [NCAP-1:0]                  fire_p;
		logic [NCAP-1:0]                  fire_s;
		logic [NCAP-1:0]                  part_p;
		logic [NCAP-1:0]                  part_s;
		logic [NCAP-1:0][CNT_W-1:0]       count;
		logic [NPORT-1:0]                 port_en;
		logic [NPORT-1:0]                 port_fp;
		logic [NPORT-1:0]                 port_fs;
		logic [NPORT-1:0][SEL_W-1:0]      port_sel;
		logic [NPORT-1:0][MODE_W-1:0]     port_mode;
		logic [NPORT-1:0][PNUM_W-1:0]     port_part;
		logic [NPORT-1:0][DEV_W-1:0]      port_dev;
		logic [NPORT-1:0][31:0]           port_fs_reg;
		logic [NPART-1:0]                 part_en;
		logic [NPART-1:0]                 part_fp;
		logic [NPART-1:0]                 part_fs;
		logic [NPART-1:0][SEL_W-1:0]      part_sel;
		logic [NPART-1:0][STATE_W-1:0]    part_state;
		logic [NPART-1:0][STATE_W-1:0]    part_pstate;
		logic [NPART-1:0][STATE_W-1:0]    part_sstate;
		logic [31:0]                      rdata;
		logic                             slverr;
	} fot_state_t;

	localparam fot_state_t FOT_STATE_RST = '0;

	typedef struct packed {
		logic [NCAP-1:0] s1;
		logic [NCAP-1:0] s2;
	} fot_sync_state_t;

	typedef struct packed {
		logic [TICK_W-1:0] cnt;
		logic              tick;
	} fot_tick_state_t;

endpackage : fot_pkg

// ### hw/fot_sync.sv
`timescale 1ns/1ps
`default_nettype none

module fot_sync
	import fot_pkg::*;
(
	input  wire logic            clock,
	input  wire logic            rst_n,
	input  wire logic [NCAP-1:0] pin_async,
	output logic      [NCAP-1:0] pin_sync
);

	fot_sync_state_t s;
	fot_sync_state_t n;

	always_comb begin
		n = s;
		n.s1 = pin_async;
		n.s2 = s.s1;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign pin_sync = s.s2;

endmodule : fot_sync

`default_nettype wire

// ### hw/fot_usec_tick.sv
`timescale 1ns/1ps
`default_nettype none

module fot_usec_tick
	import fot_pkg::*;
(
	input  wire logic clock,
	input  wire logic rst_n,
	output logic      usec_tick
);

	fot_tick_state_t s;
	fot_tick_state_t n;

	always_comb begin
		n = s;
		n.tick = 1'b0;
		if (s.cnt == TICK_LAST) begin
			n.cnt  = '0;
			n.tick = 1'b1;
		end else begin
			n.cnt = s.cnt + 7'h1;
		end
	end

	// only the fundamental reset stops the time base
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign usec_tick = s.tick;

endmodule : fot_usec_tick

`default_nettype wire

// ### hw/fot_top.sv
// Summary of operation
// RQ1 - four capabilities broadcast primary or secondary failover
// RQ2 - port reacts if enabled and selector matches
// RQ3 - partition reacts if enabled and selector matches
// RQ4 - writing one to trigger bit fires
// RQ5 - primary mode gives secondary, and reverse
// RQ6 - trigger pin n drives capability n
// RQ7 - pin ignored while pin trigger disabled
// RQ8 - polarity picks edge for secondary failover
// RQ9 - keep pin still while polarity changes
// RQ10 - pin toggles at most once per second
// RQ11 - watchdog one-to-zero step fires when enabled
// RQ12 - watchdog decrements each microsecond, stops at zero
// RQ13 - watchdog write at any time rearms it
// RQ14 - watchdog survives all but fundamental reset
// RQ15 - several trigger policies may be enabled together
// RQ16 - only one failover in progress at once
// RQ17 - primary failover copies port targets, sets flag
// RQ18 - ports reconfigure before partition state changes
// RQ19 - mode field follows the failover just issued
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module fot_top
	import fot_pkg::*;
(
	input  wire logic                            clock,
	input  wire logic                            rst_n,
	input  wire logic                            soft_reset_n,
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [11:0]                     paddr,
	input  wire logic [31:0]                     pwdata,
	output logic      [31:0]                     prdata,
	output logic                                 pready,
	output logic                                 pslverr,
	input  wire logic [NCAP-1:0]                 trigger_input_pin,
	output logic      [NCAP-1:0]                 capability_primary_fire,
	output logic      [NCAP-1:0]                 capability_secondary_fire,
	output logic      [NPORT-1:0][MODE_W-1:0]    port_operating_mode,
	output logic      [NPORT-1:0][PNUM_W-1:0]    port_partition,
	output logic      [NPORT-1:0][DEV_W-1:0]     port_device_number,
	output logic      [NPART-1:0][STATE_W-1:0]   partition_state
);

	fot_state_t s;
	fot_state_t n;

	logic [NCAP-1:0]  pin_sync;
	logic             usec_tick;
	logic [1:0]       a_blk;
	logic [1:0]       a_idx;
	logic [1:0]       a_sel;
	logic             mapped;
	logic             setup;
	logic             wr;
	logic [NCAP-1:0]  cap_hit;
	logic [NCAP-1:0]  sw_go;
	logic [NCAP-1:0]  tmr_wr;
	logic [NCAP-1:0]  tmr_go;
	logic [NCAP-1:0]  pin_rise;
	logic [NCAP-1:0]  pin_fall;
	logic [NCAP-1:0]  pin_sec;
	logic [NCAP-1:0]  pin_pri;
	logic [NCAP-1:0]  gen_go;
	logic [NCAP-1:0]  want_s;
	logic [NCAP-1:0]  want_p;
	logic [31:0]      rd_word;
	logic [CNT_W-1:0] cnt_keep [NCAP];

	fot_sync u_sync (
		.clock     (clock),
		.rst_n     (rst_n),
		.pin_async (trigger_input_pin),
		.pin_sync  (pin_sync)
	);

	fot_usec_tick u_tick (
		.clock     (clock),
		.rst_n     (rst_n),
		.usec_tick (usec_tick)
	);

	assign a_blk = paddr[7:6];
	assign a_idx = paddr[5:4];
	assign a_sel = paddr[3:2];
	assign setup = psel && !penable;

	always_comb begin
		mapped = 1'b0;
		if (paddr[11:8] != 4'h0 || paddr[1:0] != 2'h0) begin
			mapped = 1'b0;
		end else if (a_sel == 2'h3) begin
			mapped = 1'b0;
		end else if (a_blk == BLK_CAP || a_blk == BLK_PORT) begin
			mapped = 1'b1;
		end else if (a_blk == BLK_PART) begin
			mapped = (32'(a_idx) < NPART);
		end
	end

	// writes act only at the access edge; pready is always high
	assign wr = psel && penable && pwrite && mapped;

	genvar c;
	generate
		for (c = 0; c < NCAP; c++) begin : g_cap
			assign cap_hit[c] = (a_blk == BLK_CAP) && (a_idx == 2'(c));
			assign sw_go[c]   = wr && cap_hit[c] && (a_sel == REG_CTL)
				&& pwdata[CTL_SWTRIG_BIT]; // [RQ4]
			assign tmr_wr[c]  = wr && cap_hit[c] && (a_sel == REG_TMR);
			// pin c belongs to capability c only
			assign pin_rise[c] = s.armed && pin_sync[c]
				&& !s.pin_prev[c]; // [RQ6]
			assign pin_fall[c] = s.armed && !pin_sync[c]
				&& s.pin_prev[c];
			assign pin_sec[c] = s.sig_en[c] && (s.sig_pol[c] ?
				pin_fall[c] : pin_rise[c]); // [RQ7] [RQ8]
			assign pin_pri[c] = s.sig_en[c] && (s.sig_pol[c] ?
				pin_rise[c] : pin_fall[c]); // [RQ7] [RQ8]
			// a rearm in the same cycle beats the expiry
			assign tmr_go[c] = s.tim_en[c] && usec_tick && !tmr_wr[c]
				&& (s.count[c] == CNT_ONE); // [RQ11]
			// software and timer policies are ored, neither locks out the other
			assign gen_go[c] = sw_go[c] || tmr_go[c]; // [RQ15]
			assign want_s[c] = pin_sec[c] || (gen_go[c]
				&& s.mode[c] == MODE_PRIMARY); // [RQ5]
			assign want_p[c] = !want_s[c] && (pin_pri[c] || (gen_go[c]
				&& s.mode[c] == MODE_SECONDARY)); // [RQ5]
		end
	endgenerate

	always_comb begin
		n = s;
		rd_word = '0;
		n.armed = 1'b1;
		n.pin_prev = pin_sync;
		n.fire_p = want_p; // [RQ1]
		n.fire_s = want_s; // [RQ1]
		// partitions see the event one cycle after the ports
		n.part_p = s.fire_p; // [RQ18]
		n.part_s = s.fire_s; // [RQ18]

		for (int i = 0; i < NCAP; i++) begin
			if (setup && cap_hit[i]) begin
				if (a_sel == REG_CTL) begin
					rd_word[CTL_SIGEN_BIT]  = s.sig_en[i];
					rd_word[CTL_SIGPOL_BIT] = s.sig_pol[i];
					rd_word[CTL_TIMEN_BIT]  = s.tim_en[i];
				end else if (a_sel == REG_STS) begin
					rd_word[STS_MODE_BIT] = s.mode[i];
				end else if (a_sel == REG_TMR) begin
					rd_word = s.count[i];
				end
			end
			if (wr && cap_hit[i] && a_sel == REG_CTL) begin
				n.sig_en[i]  = pwdata[CTL_SIGEN_BIT];
				n.sig_pol[i] = pwdata[CTL_SIGPOL_BIT];
				n.tim_en[i]  = pwdata[CTL_TIMEN_BIT];
			end
			if (wr && cap_hit[i] && a_sel == REG_STS) begin
				n.mode[i] = pwdata[STS_MODE_BIT];
			end
			if (want_s[i]) begin
				n.mode[i] = MODE_SECONDARY; // [RQ19]
			end else if (want_p[i]) begin
				n.mode[i] = MODE_PRIMARY; // [RQ19]
			end
			if (tmr_wr[i]) begin
				n.count[i] = pwdata; // [RQ13]
			end else if (usec_tick && s.count[i] != '0) begin
				n.count[i] = s.count[i] - CNT_ONE; // [RQ12]
			end
		end

		for (int p = 0; p < NPORT; p++) begin
			if (setup && a_blk == BLK_PORT && a_idx == 2'(p)) begin
				if (a_sel == REG_CTL) begin
					rd_word[EN_BIT] = s.port_en[p];
					rd_word[SEL_LSB +: SEL_W] = s.port_sel[p];
					rd_word[PORT_MODE_LSB +: MODE_W] = s.port_mode[p];
					rd_word[PORT_PART_LSB +: PNUM_W] = s.port_part[p];
					rd_word[PORT_DEV_LSB +: DEV_W] = s.port_dev[p];
				end else if (a_sel == REG_FCTL) begin
					rd_word = s.port_fs_reg[p];
				end else if (a_sel == REG_PSTS) begin
					rd_word[FLAG_PRI_BIT] = s.port_fp[p];
					rd_word[FLAG_SEC_BIT] = s.port_fs[p];
				end
			end
			if (wr && a_blk == BLK_PORT && a_idx == 2'(p)) begin
				if (a_sel == REG_CTL) begin
					n.port_en[p]   = pwdata[EN_BIT];
					n.port_sel[p]  = pwdata[SEL_LSB +: SEL_W];
					n.port_mode[p] = pwdata[PORT_MODE_LSB +: MODE_W];
					n.port_part[p] = pwdata[PORT_PART_LSB +: PNUM_W];
					n.port_dev[p]  = pwdata[PORT_DEV_LSB +: DEV_W];
				end else if (a_sel == REG_FCTL) begin
					n.port_fs_reg[p] = pwdata;
				end else if (a_sel == REG_PSTS) begin
					n.port_fp[p] = s.port_fp[p] && !pwdata[FLAG_PRI_BIT];
					n.port_fs[p] = s.port_fs[p] && !pwdata[FLAG_SEC_BIT];
				end
			end
			// a failover event overrides a same-cycle write and clear
			if (s.port_en[p] && s.fire_p[s.port_sel[p]]) begin // [RQ2]
				n.port_mode[p] = s.port_fs_reg[p][FS_PRI_LSB + FS_MODE_OFS
					+: MODE_W]; // [RQ17]
				n.port_part[p] = s.port_fs_reg[p][FS_PRI_LSB + FS_PART_OFS
					+: PNUM_W]; // [RQ17]
				n.port_dev[p]  = s.port_fs_reg[p][FS_PRI_LSB + FS_DEV_OFS
					+: DEV_W]; // [RQ17]
				n.port_fp[p]   = 1'b1; // [RQ17]
			end else if (s.port_en[p] && s.fire_s[s.port_sel[p]]) begin // [RQ2]
				n.port_mode[p] = s.port_fs_reg[p][FS_SEC_LSB + FS_MODE_OFS
					+: MODE_W];
				n.port_part[p] = s.port_fs_reg[p][FS_SEC_LSB + FS_PART_OFS
					+: PNUM_W];
				n.port_dev[p]  = s.port_fs_reg[p][FS_SEC_LSB + FS_DEV_OFS
					+: DEV_W];
				n.port_fs[p]   = 1'b1;
			end
		end

		for (int k = 0; k < NPART; k++) begin
			if (setup && a_blk == BLK_PART && a_idx == 2'(k)) begin
				if (a_sel == REG_CTL) begin
					rd_word[EN_BIT] = s.part_en[k];
					rd_word[SEL_LSB +: SEL_W] = s.part_sel[k];
					rd_word[PART_STATE_LSB +: STATE_W] = s.part_state[k];
				end else if (a_sel == REG_FCTL) begin
					rd_word[FS_PRI_LSB +: STATE_W] = s.part_pstate[k];
					rd_word[FS_SEC_LSB +: STATE_W] = s.part_sstate[k];
				end else if (a_sel == REG_PSTS) begin
					rd_word[FLAG_PRI_BIT] = s.part_fp[k];
					rd_word[FLAG_SEC_BIT] = s.part_fs[k];
				end
			end
			if (wr && a_blk == BLK_PART && a_idx == 2'(k)) begin
				if (a_sel == REG_CTL) begin
					n.part_en[k]    = pwdata[EN_BIT];
					n.part_sel[k]   = pwdata[SEL_LSB +: SEL_W];
					n.part_state[k] = pwdata[PART_STATE_LSB +: STATE_W];
				end else if (a_sel == REG_FCTL) begin
					n.part_pstate[k] = pwdata[FS_PRI_LSB +: STATE_W];
					n.part_sstate[k] = pwdata[FS_SEC_LSB +: STATE_W];
				end else if (a_sel == REG_PSTS) begin
					n.part_fp[k] = s.part_fp[k] && !pwdata[FLAG_PRI_BIT];
					n.part_fs[k] = s.part_fs[k] && !pwdata[FLAG_SEC_BIT];
				end
			end
			if (s.part_en[k] && s.part_p[s.part_sel[k]]) begin // [RQ3]
				n.part_state[k] = s.part_pstate[k]; // [RQ18]
				n.part_fp[k]    = 1'b1;
			end else if (s.part_en[k] && s.part_s[s.part_sel[k]]) begin // [RQ3]
				n.part_state[k] = s.part_sstate[k]; // [RQ18]
				n.part_fs[k]    = 1'b1;
			end
		end

		if (setup) begin
			n.rdata  = rd_word;
			n.slverr = !mapped;
		end

		// a soft reset clears everything but the running watchdogs
		for (int i = 0; i < NCAP; i++) begin
			cnt_keep[i] = n.count[i];
		end
		if (!soft_reset_n) begin
			n = FOT_STATE_RST;
			for (int i = 0; i < NCAP; i++) begin
				n.count[i] = cnt_keep[i]; // [RQ14]
			end
		end
	end

	// rst_n is the fundamental reset, the only one that stops a watchdog
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s <= FOT_STATE_RST; // [RQ14]
		end else begin
			s <= n;
		end
	end

	assign prdata                    = s.rdata;
	assign pready                    = 1'b1;
	assign pslverr                   = s.slverr;
	assign capability_primary_fire   = s.fire_p;
	assign capability_secondary_fire = s.fire_s;
	assign port_operating_mode       = s.port_mode;
	assign port_partition            = s.port_part;
	assign port_device_number        = s.port_dev;
	assign partition_state           = s.part_state;

endmodule : fot_top

`default_nettype wire

// ### tb/fot_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module fot_top_properties
	import fot_pkg::*;
(
	input wire logic                          clock,
	input wire logic                          rst_n,
	input wire logic                          soft_reset_n,
	input wire logic                          psel,
	input wire logic                          penable,
	input wire logic                          pwrite,
	input wire logic [11:0]                   paddr,
	input wire logic [31:0]                   pwdata,
	input wire logic [NCAP-1:0]               capability_primary_fire,
	input wire logic [NCAP-1:0]               capability_secondary_fire,
	input wire logic [NPORT-1:0][MODE_W-1:0]  port_operating_mode,
	input wire logic [NPORT-1:0][PNUM_W-1:0]  port_partition,
	input wire logic [NPORT-1:0][DEV_W-1:0]   port_device_number,
	input wire logic [NPART-1:0][STATE_W-1:0] partition_state
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire [NCAP-1:0] fire;
	wire            wr;
	assign fire = capability_primary_fire | capability_secondary_fire;
	assign wr   = psel && penable && pwrite;
	sequence sw_trig_s;
		wr && soft_reset_n && paddr[11:6] == 6'h0 && paddr[3:0] == 4'h0
			&& pwdata[0];
	endsequence
	sequence fire_s;
		(|fire) && !wr && soft_reset_n;
	endsequence
	a_sw_trig_fires: assert property (sw_trig_s ##1 soft_reset_n
		|-> fire == (4'h1 << $past(paddr[5:4])))
		else $error("software trigger did not fire its capability");
	a_fire_one_type: assert property (
		(capability_primary_fire & capability_secondary_fire) == '0)
		else $error("primary and secondary fired together");
	a_fire_one_cap: assert property ($onehot0(fire))
		else $error("several capabilities fired at once");
	a_fire_one_cycle: assert property ((|fire) |=> fire == '0)
		else $error("fire pulse longer than one cycle");
	a_soft_rst_quiet: assert property (!soft_reset_n |=> fire == '0)
		else $error("fire during soft reset");
	a_port_after_fire: assert property (
		$changed({port_operating_mode, port_partition, port_device_number})
		|-> $past(|fire) || $past(wr) || $past(!soft_reset_n))
		else $error("port fields changed without cause");
	a_part_after_port: assert property ($changed(partition_state)
		|-> $past(|fire, 2) || $past(wr) || $past(!soft_reset_n))
		else $error("partition state changed without cause");
	a_part_waits_port: assert property (fire_s |=> $stable(partition_state))
		else $error("partition changed before ports");
endmodule : fot_top_properties
bind fot_top fot_top_properties u_props (.clock(clock), .rst_n(rst_n),
	.soft_reset_n(soft_reset_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.capability_primary_fire(capability_primary_fire),
	.capability_secondary_fire(capability_secondary_fire),
	.port_operating_mode(port_operating_mode), .port_partition(port_partition),
	.port_device_number(port_device_number), .partition_state(partition_state));
`default_nettype wire

// ### tb/fot_pin_driver.sv
`timescale 1ns/1ps
`default_nettype none
module fot_pin_driver
	import fot_pkg::*;
#(
	parameter int GAP = 40
)(
	input  wire logic            clock,
	input  wire logic            rst_n,
	input  wire logic [NCAP-1:0] toggle_req,
	output logic      [NCAP-1:0] pin,
	output logic                 busy
);
	int quiet;
	assign busy = quiet != 0;
	// gap stands in for the one second minimum between pin changes
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pin   <= '0;
			quiet <= 0;
		end else if (quiet != 0) begin
			quiet <= quiet - 1;
		end else if (toggle_req != '0) begin
			pin   <= pin ^ toggle_req;
			quiet <= GAP;
		end
	end
endmodule : fot_pin_driver
`default_nettype wire

// ### tb/fot_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fot_top_tb
	import fot_pkg::*;
;
	logic                          clock = 1'b0;
	logic                          rst_n = 1'b0;
	logic                          soft_reset_n = 1'b1;
	logic                          psel = 1'b0;
	logic                          penable = 1'b0;
	logic                          pwrite = 1'b0;
	logic [11:0]                   paddr = 12'h0;
	logic [31:0]                   pwdata = 32'h0;
	logic [NCAP-1:0]               toggle_req = '0;
	logic [NCAP-1:0]               lvl = '0;
	logic [31:0]                   prdata;
	logic                          pready;
	logic                          pslverr;
	logic                          busy;
	logic [NCAP-1:0]               pin;
	logic [NCAP-1:0]               pf;
	logic [NCAP-1:0]               sf;
	logic [NPORT-1:0][MODE_W-1:0]  pmode;
	logic [NPORT-1:0][PNUM_W-1:0]  ppart;
	logic [NPORT-1:0][DEV_W-1:0]   pdev;
	logic [NPART-1:0][STATE_W-1:0] pstate;
	logic [31:0]                   fs_a [NPORT];
	logic [31:0]                   ct_a [NPORT];
	logic                          mode_m [NCAP];
	logic [31:0]                   pf_a [NPART];
	logic [31:0]                   pc_a [NPART];
	int                            fail_count = 0;
	int                            tests_run = 0;
	int                            cycles = 0;
	integer                        seed = 32'hf3293753;
	always #5 clock = ~clock;
	fot_top dut (.clock(clock), .rst_n(rst_n), .soft_reset_n(soft_reset_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.trigger_input_pin(pin), .capability_primary_fire(pf),
		.capability_secondary_fire(sf), .port_operating_mode(pmode),
		.port_partition(ppart), .port_device_number(pdev),
		.partition_state(pstate));
	fot_pin_driver #(.GAP(40)) u_pins (.clock(clock), .rst_n(rst_n),
		.toggle_req(toggle_req), .pin(pin), .busy(busy));
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 10000) begin
			fail_count++;
			finish_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask : wr
	function automatic logic [NCAP-1:0] onehot(input int c);
		return NCAP'(1) << c;
	endfunction : onehot
	// fire seen within n cycles; waiting it out keeps one failover at a time
	task automatic trig_chk(input int c, input logic sec, input logic en,
		input int n);
		logic [NCAP-1:0] p;
		logic [NCAP-1:0] s;
		p = '0;
		s = '0;
		repeat (n) begin
			@(posedge clock);
			if ((pf | sf) !== '0 && (p | s) == '0) begin
				p = pf;
				s = sf;
			end
		end
		chk("primary_fire", 32'((en && !sec) ? onehot(c) : NCAP'(0)), 32'(p));
		chk("secondary_fire", 32'((en && sec) ? onehot(c) : NCAP'(0)), 32'(s));
		if (en) mode_m[c] = sec;
	endtask : trig_chk
	initial begin
		logic [31:0] q;
		logic [31:0] q2;
		logic [12:0] m;
		logic        e;
		logic        sec;
		int          c;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		foreach (mode_m[i]) mode_m[i] = MODE_PRIMARY;
		apb(1'b0, 12'h004, 32'h0, q, e);
		chk("mode_reset", 32'h0, q);
		apb(1'b0, 12'h00c, 32'h0, q, e);
		chk("unmapped_err", 32'h1, 32'(e));
		$display("test reset done");
		for (int r = 0; r < 2 * NCAP; r++) begin
			c = $unsigned($random(seed)) % NCAP;
			// software may set the mode itself; the next trigger follows it
			if (r[0]) begin
				mode_m[c] = ~mode_m[c];
				wr(12'(16 * c + 4), 32'(mode_m[c]));
			end
			wr(12'(16 * c), 32'h1);
			trig_chk(c, mode_m[c] == MODE_PRIMARY, 1'b1, 8);
			apb(1'b0, 12'(16 * c + 4), 32'h0, q, e);
			chk("mode_field", 32'(mode_m[c]), q);
		end
		$display("test software trigger done");
		c = $unsigned($random(seed)) % NCAP;
		for (int p = 0; p < NPORT; p++) begin
			fs_a[p] = $random(seed);
			ct_a[p] = ($random(seed) & 32'h001f0ff0) | 32'(p != 3)
				| 32'((p == 2 ? (c + 1) % NCAP : c) << 1);
			wr(12'(16 * p + 'h44), fs_a[p]);
			wr(12'(16 * p + 'h40), ct_a[p]);
		end
		for (int k = 0; k < NPART; k++) begin
			pf_a[k] = $random(seed);
			pc_a[k] = ($random(seed) & 32'h30) | 32'(c << 1) | 32'(k == 0);
			wr(12'(16 * k + 'h84), pf_a[k]);
			wr(12'(16 * k + 'h80), pc_a[k]);
		end
		sec = mode_m[c] == MODE_PRIMARY;
		wr(12'(16 * c), 32'h1);
		trig_chk(c, sec, 1'b1, 8);
		for (int p = 0; p < NPORT; p++) begin
			q = sec ? fs_a[p] >> 16 : fs_a[p];
			m = (p < 2) ? {q[12:8], q[7:4], q[3:0]}
				: {ct_a[p][20:16], ct_a[p][11:8], ct_a[p][7:4]};
			chk("port_fields", 32'(m), 32'({pdev[p], ppart[p], pmode[p]}));
			apb(1'b0, 12'(16 * p + 'h48), 32'h0, q, e);
			chk("port_flag", (p < 2) ? (sec ? 32'h2 : 32'h1) : 32'h0, q);
			wr(12'(16 * p + 'h48), 32'h3);
			apb(1'b0, 12'(16 * p + 'h48), 32'h0, q, e);
			chk("port_flag_clr", 32'h0, q);
		end
		for (int k = 0; k < NPART; k++) begin
			q = sec ? pf_a[k] >> 16 : pf_a[k];
			chk("part_state", 32'(k == 0 ? q[1:0] : pc_a[k][5:4]),
				32'(pstate[k]));
			apb(1'b0, 12'(16 * k + 'h84), 32'h0, q, e);
			chk("part_settings", pf_a[k] & 32'h00030003, q);
			apb(1'b0, 12'(16 * k + 'h88), 32'h0, q, e);
			chk("part_flag", (k == 0) ? (sec ? 32'h2 : 32'h1) : 32'h0, q);
		end
		$display("test reaction done");
		for (int k = 0; k < 6; k++) begin
			c = k % NCAP;
			wr(12'(16 * c), {29'h0, k[0], k != 0, 1'b0});
			while (busy !== 1'b0) @(posedge clock);
			toggle_req <= onehot(c);
			@(posedge clock);
			toggle_req <= '0;
			lvl[c] = ~lvl[c];
			trig_chk(c, lvl[c] ^ k[0], k != 0, 12);
		end
		$display("test pin trigger done");
		c = $unsigned($random(seed)) % NCAP;
		wr(12'(16 * c), 32'ha);
		wr(12'(16 * c + 8), 32'd500);
		apb(1'b0, 12'(16 * c + 8), 32'h0, q, e);
		repeat (CYCLES_PER_US - 3) @(posedge clock);
		apb(1'b0, 12'(16 * c + 8), 32'h0, q2, e);
		chk("count_step", 32'h1, q - q2);
		wr(12'(16 * c + 8), 32'h2);
		trig_chk(c, mode_m[c] == MODE_PRIMARY, 1'b1, 3 * CYCLES_PER_US);
		apb(1'b0, 12'(16 * c + 8), 32'h0, q, e);
		chk("count_stop", 32'h0, q);
		// expiry with the timer policy off must fire nothing
		wr(12'(16 * c), 32'h0);
		wr(12'(16 * c + 8), 32'h1);
		trig_chk(c, 1'b0, 1'b0, 2 * CYCLES_PER_US);
		apb(1'b0, 12'(16 * c + 8), 32'h0, q, e);
		chk("count_idle", 32'h0, q);
		$display("test watchdog done");
		wr(12'h010, 32'h0);
		wr(12'h018, 32'd300);
		// at least one microsecond step must pass before the count is read
		repeat (CYCLES_PER_US) @(posedge clock);
		soft_reset_n <= 1'b0;
		repeat (2) @(posedge clock);
		soft_reset_n <= 1'b1;
		apb(1'b0, 12'h018, 32'h0, q, e);
		chk("count_kept", 32'h1, 32'(q > 0 && q < 300));
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		apb(1'b0, 12'h018, 32'h0, q, e);
		chk("count_cleared", 32'h0, q);
		$display("test resets done");
		finish_test();
	end
endmodule : fot_top_tb
`default_nettype wire
